/* File: hdl/afp_top.sv */
// What this block does
// - A read cut short inside an entry's first byte drops that entry's rest; reading moves on.
// - A read cut short inside an entry's second byte drops whatever is left of that entry.
// - Entries after a cut-short read stay intact; the host ignores each entry's 4 leading bits.
// - A cut-short register write of 4 or more bits loads the bits shifted so far, from the MSB downward; shorter ones do nothing.
// - Bits a cut-short write did not reach keep their earlier values.
// - Results are straight binary, one code step being the reference over 1024.
// - Each entry goes out MSB first as 4 zeros, the 10-bit result, then 2 zeros.
// - Serial input is sampled on rising clock edges and output changes on falling edges.
// - A reset-register write of 5 or more bits resets all registers with bit 3 low, else only empties the FIFO and clears its overflow and corrupt flags.
`timescale 1ns/1ps
`default_nettype none
module afp_top (
  // Core clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  output logic            dout_oe,
  // Converter core
  input  wire logic       res_valid,
  input  wire logic [9:0] res_data,
  input  wire logic       scan_done,
  input  wire logic       conv_busy,
  // Register contents
  output logic [7:0]      conv_reg,
  output logic [7:0]      setup_reg,
  output logic [7:0]      avg_reg,
  output logic            conv_wr,
  // Status
  output logic            eoc_n,
  output logic            conv_abort,
  output logic            fifo_corrupt,
  output logic            fifo_ovf,
  output logic [4:0]      fifo_level
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [9:0]       mem [afp_pkg::FIFO_DEPTH];
  logic [3:0]       wr_q;
  logic [3:0]       rd_q;
  logic [4:0]       cnt_q;
  logic [3:0]       sy1_q;
  logic [3:0]       sy2_q;
  logic [3:0]       prev_q;
  logic             used_q;
  logic             fpar_q;
  logic [1:0][15:0] slot_q;
  logic [7:0]       conv_q;
  logic [7:0]       setup_q;
  logic [7:0]       avg_q;
  logic             conv_wr_q;
  logic             eoc_n_q;
  logic             abort_q;
  logic             corrupt_q;
  logic             ovf_q;
  // Link side values
  logic             ent_tgl;
  logic             byte_tgl;
  logic             act_tgl;
  logic [7:0]       wbyte;
  logic [7:0]       shift;
  logic [2:0]       nbits;
  logic [3:0]       bpos;
  // Events
  logic             cs_rise;
  logic             cs_fall;
  logic             ent_ev;
  logic             byte_ev;
  logic             act_ev;
  logic             fend;
  logic             part_pop;
  logic             part_wr;
  logic             push;
  logic             full;
  logic [1:0]       pop_req;
  logic [1:0]       pop_n;
  // Register write path
  logic [3:0]       shamt;
  logic             wr_en;
  logic [7:0]       wr_val;
  logic [7:0]       wr_mask;
  logic             sel_conv;
  logic             sel_setup;
  logic             sel_avg;
  logic             sel_rst;
  logic             rst_all;
  logic             fifo_clr;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] val,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction

  // ------------------------------------------------------------
  // Link domain
  // ------------------------------------------------------------
  afp_link u_link (
    .sclk     (sclk),
    .reset    (reset),
    .cs_n     (cs_n),
    .din      (din),
    .dout     (dout),
    .dout_oe  (dout_oe),
    .slot0    (slot_q[0]),
    .slot1    (slot_q[1]),
    .ent_tgl  (ent_tgl),
    .byte_tgl (byte_tgl),
    .act_tgl  (act_tgl),
    .wbyte    (wbyte),
    .shift    (shift),
    .nbits    (nbits),
    .bpos     (bpos)
  );

  // ------------------------------------------------------------
  // Crossing into the core clock
  // ------------------------------------------------------------
  // Toggles and the frame level cross on two flops each; the counts and
  // shifted bits are read only once the frame end has crossed, when the
  // link clock has stopped and they are steady.
  always_ff @(posedge mclk) begin
    if (reset) begin
      sy1_q  <= afp_pkg::SYNC_RST;
      sy2_q  <= afp_pkg::SYNC_RST;
      prev_q <= afp_pkg::SYNC_RST;
    end else begin
      sy1_q  <= {act_tgl, byte_tgl, ent_tgl, cs_n};
      sy2_q  <= sy1_q;
      prev_q <= sy2_q;
    end
  end

  assign cs_rise = sy2_q[afp_pkg::SY_CS] & ~prev_q[afp_pkg::SY_CS];
  assign cs_fall = ~sy2_q[afp_pkg::SY_CS] & prev_q[afp_pkg::SY_CS];
  assign ent_ev  = sy2_q[afp_pkg::SY_ENT] ^ prev_q[afp_pkg::SY_ENT];
  assign byte_ev = sy2_q[afp_pkg::SY_BYTE] ^ prev_q[afp_pkg::SY_BYTE];
  assign act_ev  = sy2_q[afp_pkg::SY_ACT] ^ prev_q[afp_pkg::SY_ACT];

  // A frame without clock edges leaves stale counts; it must not act
  always_ff @(posedge mclk) begin
    if (reset || cs_rise) begin
      used_q <= 1'b0;
    end else if (act_ev) begin
      used_q <= 1'b1;
    end
  end

  assign fend = cs_rise & (used_q | act_ev);

  assign part_pop = fend & (bpos != 4'h0);

  assign part_wr = fend & (nbits >= afp_pkg::PART_MIN_BITS);

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  assign shamt = 4'h8 - {1'b0, nbits};

  always_comb begin
    wr_en   = 1'b0;
    wr_val  = wbyte;
    wr_mask = 8'hff;
    if (byte_ev) begin
      wr_en = 1'b1;
    end else if (part_wr) begin
      wr_en = 1'b1;
      wr_val  = 8'(shift << shamt);
      wr_mask = 8'(8'hff << shamt);
    end
  end

  assign sel_conv  = wr_val[7];
  assign sel_setup = wr_val[7:6] == afp_pkg::SEL_SETUP;
  assign sel_avg   = wr_val[7:5] == afp_pkg::SEL_AVG;
  assign sel_rst   = wr_val[7:4] == afp_pkg::SEL_RESET;

  assign fifo_clr = wr_en & sel_rst & wr_mask[afp_pkg::RST_MODE_BIT];
  assign rst_all  = fifo_clr & ~wr_val[afp_pkg::RST_MODE_BIT];

  always_ff @(posedge mclk) begin
    if (reset || rst_all) begin
      conv_q  <= afp_pkg::CONV_RST;
      setup_q <= afp_pkg::SETUP_RST;
      avg_q   <= afp_pkg::AVG_RST;
    end else if (wr_en) begin
      if (sel_conv) begin
        conv_q <= merge(conv_q, wr_val, wr_mask);
      end
      if (sel_setup) begin
        setup_q <= merge(setup_q, wr_val, wr_mask);
      end
      if (sel_avg) begin
        avg_q <= merge(avg_q, wr_val, wr_mask);
      end
    end
  end

  // Only a whole conversion byte starts work in the core
  always_ff @(posedge mclk) begin
    if (reset) begin
      conv_wr_q <= 1'b0;
    end else begin
      conv_wr_q <= byte_ev & sel_conv;
    end
  end

  // ------------------------------------------------------------
  // Result store
  // ------------------------------------------------------------
  assign full    = cnt_q == 5'(afp_pkg::FIFO_DEPTH);
  assign push    = res_valid & ~full & ~fifo_clr;
  assign pop_req = {1'b0, ent_ev} + {1'b0, part_pop};
  assign pop_n   = (5'(pop_req) > cnt_q) ? cnt_q[1:0] : pop_req;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= res_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || fifo_clr) begin
      wr_q  <= 4'h0;
      rd_q  <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      wr_q  <= 4'(wr_q + {3'h0, push});
      rd_q  <= 4'(rd_q + {2'h0, pop_n});
      cnt_q <= 5'(cnt_q + {4'h0, push} - {3'h0, pop_n});
    end
  end

  // Overflow drops the new result; the stored ones stay
  always_ff @(posedge mclk) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (res_valid && full) begin
      ovf_q <= 1'b1;
    end else if (fifo_clr) begin
      ovf_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Words offered to the link
  // ------------------------------------------------------------
  // Parity of entries finished in this frame; the link picks its slot by
  // the same parity, so a slot never changes while it is being shifted.
  always_ff @(posedge mclk) begin
    if (reset || cs_rise) begin
      fpar_q <= 1'b0;
    end else if (ent_ev) begin
      fpar_q <= ~fpar_q;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_slot
    logic [3:0] sidx;
    logic       sval;
    assign sidx = (1'(g) == fpar_q) ? rd_q : 4'(rd_q + 4'h1);
    assign sval = (1'(g) == fpar_q) ? (cnt_q != 5'h00) : (cnt_q > 5'h01);
    always_ff @(posedge mclk) begin
      if (reset) begin
        slot_q[g] <= 16'h0000;
      end else if (sval) begin
        slot_q[g] <= {4'h0, mem[sidx], 2'h0};
      end else begin
        slot_q[g] <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------
  // End of conversion and early select
  // ------------------------------------------------------------
  // A scan finishing as the frame starts still shows as done
  always_ff @(posedge mclk) begin
    if (reset) begin
      eoc_n_q <= 1'b1;
    end else if (scan_done) begin
      eoc_n_q <= 1'b0;
    end else if (cs_fall) begin
      eoc_n_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= cs_fall & eoc_n_q & conv_busy;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      corrupt_q <= 1'b0;
    end else if (cs_fall && eoc_n_q && conv_busy) begin
      corrupt_q <= 1'b1;
    end else if (fifo_clr) begin
      corrupt_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign conv_reg     = conv_q;
  assign setup_reg    = setup_q;
  assign avg_reg      = avg_q;
  assign conv_wr      = conv_wr_q;
  assign eoc_n        = eoc_n_q;
  assign conv_abort   = abort_q;
  assign fifo_corrupt = corrupt_q;
  assign fifo_ovf     = ovf_q;
  assign fifo_level   = cnt_q;
endmodule
`default_nettype wire

/* File: hdl/afp_pkg.sv */
package afp_pkg;
  // ------------------------------------------------------------
  // Result format
  // ------------------------------------------------------------
  localparam int         RES_W      = 10;
  localparam int         CODE_STEPS = 1024;
  localparam int         LEAD_W     = 4;
  localparam int         TRAIL_W    = 2;
  localparam int         ENTRY_W    = 16;
  localparam int         BYTE_W     = 8;
  // ------------------------------------------------------------
  // Result store
  // ------------------------------------------------------------
  localparam int         FIFO_DEPTH = 16;
  localparam int         PTR_W      = 4;
  localparam int         CNT_W      = 5;
  // ------------------------------------------------------------
  // Internal registers and their select codes
  // ------------------------------------------------------------
  localparam logic [7:0] CONV_RST   = 8'h00;
  localparam logic [7:0] SETUP_RST  = 8'h60;
  localparam logic [7:0] AVG_RST    = 8'h00;
  localparam logic [1:0] SEL_SETUP  = 2'h1;
  localparam logic [2:0] SEL_AVG    = 3'h1;
  localparam logic [3:0] SEL_RESET  = 4'h1;
  localparam int         RST_MODE_BIT = 3;
  localparam logic [2:0] PART_MIN_BITS = 3'h4;
  // ------------------------------------------------------------
  // Crossing bundle layout
  // ------------------------------------------------------------
  localparam int         SY_W     = 4;
  localparam int         SY_CS    = 0;
  localparam int         SY_ENT   = 1;
  localparam int         SY_BYTE  = 2;
  localparam int         SY_ACT   = 3;
  localparam logic [3:0] SYNC_RST = 4'h1;
endpackage

/* File: hdl/afp_link.sv */
`timescale 1ns/1ps
`default_nettype none
module afp_link (
  // Link pins
  input  wire logic        sclk,
  input  wire logic        reset,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // Output words from the core side
  input  wire logic [15:0] slot0,
  input  wire logic [15:0] slot1,
  // Quasi-static state read by the core side
  output logic             ent_tgl,
  output logic             byte_tgl,
  output logic             act_tgl,
  output logic [7:0]       wbyte,
  output logic [7:0]       shift,
  output logic [2:0]       nbits,
  output logic [3:0]       bpos
);
  logic        started_q;
  logic        ent_tgl_q;
  logic        byte_tgl_q;
  logic        act_tgl_q;
  logic [7:0]  wbyte_q;
  logic [7:0]  sh_q;
  logic [2:0]  nb_q;
  logic [3:0]  bpos_q;
  logic [2:0]  nb_eff;
  logic [3:0]  bpos_eff;
  logic [3:0]  opos_q;
  logic        oidx_q;
  logic        dout_q;
  logic [3:0]  npos;
  logic        nidx;
  logic [15:0] word_nxt;

  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  // Counters are not cleared by the frame so the core can read them after it
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  assign nb_eff   = started_q ? nb_q : 3'h0;
  assign bpos_eff = started_q ? bpos_q : 4'h0;

  // ------------------------------------------------------------
  // Input side
  // ------------------------------------------------------------
  // sample on rise
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      ent_tgl_q  <= 1'b0;
      byte_tgl_q <= 1'b0;
      act_tgl_q  <= 1'b0;
      wbyte_q    <= 8'h00;
      sh_q       <= 8'h00;
      nb_q       <= 3'h0;
      bpos_q     <= 4'h0;
    end else begin
      sh_q   <= {sh_q[6:0], din};
      nb_q   <= nb_eff + 3'h1;
      bpos_q <= bpos_eff + 4'h1;
      if (!started_q) begin
        act_tgl_q <= ~act_tgl_q;
      end
      if (nb_eff == 3'h7) begin
        wbyte_q    <= {sh_q[6:0], din};
        byte_tgl_q <= ~byte_tgl_q;
      end
      if (bpos_eff == 4'hf) begin
        ent_tgl_q <= ~ent_tgl_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Output side
  // ------------------------------------------------------------
  assign npos     = opos_q + 4'h1;
  assign nidx     = oidx_q ^ (opos_q == 4'hf);
  assign word_nxt = nidx ? slot1 : slot0;

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      opos_q <= 4'h0;
      oidx_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      opos_q <= npos;
      oidx_q <= nidx;
      dout_q <= word_nxt[4'hf - npos];
    end
  end

  assign dout     = dout_q;
  assign dout_oe  = ~cs_n;
  assign ent_tgl  = ent_tgl_q;
  assign byte_tgl = byte_tgl_q;
  assign act_tgl  = act_tgl_q;
  assign wbyte    = wbyte_q;
  assign shift    = sh_q;
  assign nbits    = nb_q;
  assign bpos     = bpos_q;
endmodule
`default_nettype wire

/* File: test/afp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module afp_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Link
  input wire logic       cs_n,
  input wire logic       dout,
  input wire logic       dout_oe,
  // Core side
  input wire logic       res_valid,
  input wire logic       scan_done,
  input wire logic       conv_wr,
  input wire logic [7:0] conv_reg,
  input wire logic [7:0] setup_reg,
  input wire logic [7:0] avg_reg,
  input wire logic       eoc_n,
  input wire logic       conv_abort,
  input wire logic       fifo_corrupt,
  input wire logic       fifo_ovf,
  input wire logic [4:0] fifo_level
);
  // ----
  // Quiet link
  // ----
  // Link effects land late, so the level, overflow and register checks trust only a long quiet spell
  logic [3:0] idle_q;
  always_ff @(posedge mclk) begin
    if (reset || !cs_n) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hf) begin
      idle_q <= idle_q + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  oe_tracks_cs_a: assert property (dout_oe == !cs_n)
    else $error("dout_oe disagrees with chip select");
  lead_zero_a: assert property ($fell(cs_n) |-> !dout)
    else $error("first bit not zero");
  quiet_dout_a: assert property (idle_q != 4'h0 |-> !dout)
    else $error("dout active outside frame");
  eoc_on_scan_a: assert property (scan_done |=> !eoc_n)
    else $error("eoc_n not low after scan");
  abort_marks_a: assert property (conv_abort |=> fifo_corrupt)
    else $error("abort without corrupt flag");
  abort_pulse_a: assert property (conv_abort |=> !conv_abort)
    else $error("abort longer than one cycle");
  wr_pulse_a: assert property (conv_wr |=> !conv_wr)
    else $error("conv_wr longer than one cycle");
  level_cap_a: assert property (fifo_level <= 5'h10)
    else $error("fifo level above depth");
  ovf_full_a: assert property (res_valid && fifo_level == 5'h10 && idle_q == 4'hf |=> fifo_ovf)
    else $error("overflow not flagged");
  push_count_a: assert property (res_valid && fifo_level != 5'h10 && idle_q == 4'hf
    |=> fifo_level == $past(fifo_level) + 5'h1)
    else $error("push not counted");
  regs_hold_a: assert property (idle_q == 4'hf |=> $stable(conv_reg) && $stable(setup_reg) && $stable(avg_reg))
    else $error("register changed without a write");
endmodule
`default_nettype wire

/* File: test/afp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module afp_host (
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  // Conversion status
  input  wire logic eoc_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // ----
  // One frame, n bits MSB first from tx
  // ----
  task automatic xfer(input int n, input logic [31:0] tx, input bit early, output logic [31:0] rx);
    rx = '0;
    // wait end of conversion; a hang is left to the bench watchdog
    while (!early && eoc_n !== 1'b0) begin
      #10;
    end
    #3.7;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      // drive after fall, sample at rise
      din = tx[31-i];
      #32;
      sclk = 1'b1;
      rx[31-i] = dout;
      #32;
      sclk = 1'b0;
    end
    #32;
    cs_n = 1'b1;
    // Released line shows no stale level
    din = ~din;
    #100;
  endtask
endmodule
`default_nettype wire

/* File: test/afp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module afp_top_tb;
  // ----
  // Signals and model
  // ----
  logic        mclk, reset, sclk, cs_n, din, dout, dout_oe;
  logic        res_valid, scan_done, conv_busy, conv_wr, eoc_n;
  logic        conv_abort, fifo_corrupt, fifo_ovf, m_corrupt, m_ovf;
  logic [9:0]  res_data;
  logic [7:0]  conv_reg, setup_reg, avg_reg, m_conv, m_setup, m_avg;
  logic [4:0]  fifo_level;
  logic [9:0]  q[$];
  logic [31:0] wr[6];
  int          wn[6];
  int          mismatches, check_count, seed;
  int          n_wr, n_abort, m_wr, m_abort;
  afp_top dut (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .res_valid(res_valid), .res_data(res_data), .scan_done(scan_done),
    .conv_busy(conv_busy), .conv_reg(conv_reg), .setup_reg(setup_reg), .avg_reg(avg_reg),
    .conv_wr(conv_wr), .eoc_n(eoc_n), .conv_abort(conv_abort), .fifo_corrupt(fifo_corrupt),
    .fifo_ovf(fifo_ovf), .fifo_level(fifo_level)
  );
  afp_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .eoc_n(eoc_n));
  always #5 mclk = ~mclk;
  // Pulses counted away from the edge that launches them
  always @(negedge mclk) begin
    if (conv_wr === 1'b1) n_wr++;
    if (conv_abort === 1'b1) n_abort++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic push(input int k);
    logic [9:0] v;
    for (int i = 0; i < k; i++) begin
      @(posedge mclk);
      v = 10'($random(seed));
      res_valid <= 1'b1;
      res_data  <= v;
      if (q.size() < afp_pkg::FIFO_DEPTH) q.push_back(v);
      else m_ovf = 1'b1;
    end
    @(posedge mclk);
    res_valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Partial bytes merge from the MSB down; short ones do nothing
  function automatic void apply(input logic [7:0] b, input int k);
    logic [7:0] m;
    m = (k >= 8) ? 8'hff : 8'hff << (8 - k);
    if (b[7] && k >= 8) m_wr++;
    if (k < 4) return;
    if (b[7]) m_conv = (m_conv & ~m) | (b & m);
    else if (b[6]) m_setup = (m_setup & ~m) | (b & m);
    else if (b[5]) m_avg = (m_avg & ~m) | (b & m);
    else if (b[4] && k >= 5) begin
      q.delete();
      m_corrupt = 1'b0;
      m_ovf = 1'b0;
      if (!b[3]) begin
        m_conv  = afp_pkg::CONV_RST;
        m_setup = afp_pkg::SETUP_RST;
        m_avg   = afp_pkg::AVG_RST;
      end
    end
  endfunction
  task automatic frame(input int n, input logic [31:0] tx, input bit early);
    logic [31:0] rx;
    logic [31:0] ex;
    logic [15:0] ent;
    ex = '0;
    if (!early) begin
      @(posedge mclk);
      scan_done <= 1'b1;
      @(posedge mclk);
      scan_done <= 1'b0;
    end
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      if (i / 16 < q.size()) begin
        ent = {4'h0, q[i/16], 2'h0};
        ex[31-i] = ent[15 - i % 16];
      end
    end
    m_corrupt |= early;
    if (early && conv_busy) m_abort++;
    host.xfer(n, tx, early, rx);
    repeat (3) @(posedge mclk);
    for (int i = 0; i < n; i += 16) begin
      if (q.size() > 0) void'(q.pop_front());
    end
    for (int i = 0; i < n; i += 8) apply(tx[31-i -: 8], n - i);
    check("read_bits", rx, ex);
    check("fifo_level", fifo_level, q.size());
    check("conv_reg", conv_reg, m_conv);
    check("setup_reg", setup_reg, m_setup);
    check("avg_reg", avg_reg, m_avg);
    check("fifo_corrupt", fifo_corrupt, m_corrupt);
    check("fifo_ovf", fifo_ovf, m_ovf);
    check("conv_wr", n_wr, m_wr);
    check("conv_abort", n_abort, m_abort);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    res_valid = 1'b0;
    res_data = 10'h000;
    scan_done = 1'b0;
    conv_busy = 1'b0;
    seed = 32'ha6e3;
    m_conv = afp_pkg::CONV_RST;
    m_setup = afp_pkg::SETUP_RST;
    m_avg = afp_pkg::AVG_RST;
    m_corrupt = 1'b0;
    m_ovf = 1'b0;
    wr = '{32'h2c000000, 32'h85000000, 32'hd0000000, 32'h7a000000, 32'h44000000, 32'h3fa10000};
    wn = '{8, 8, 5, 8, 6, 16};
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check("eoc_n", eoc_n, 1'b1);
    check("setup_reg", setup_reg, m_setup);
    push(4);
    frame(5, 32'h0, 1'b0);
    frame(12, 32'h0, 1'b0);
    frame(32, 32'h0, 1'b0);
    foreach (wr[i]) frame(wn[i], wr[i], 1'b0);
    push(3);
    frame(8, 32'h18000000, 1'b0);
    conv_busy <= 1'b1;
    frame(8, 32'h0, 1'b1);
    conv_busy <= 1'b0;
    push(17);
    frame(4, 32'h10000000, 1'b0);
    frame(5, 32'h18000000, 1'b0);
    frame(8, 32'h10000000, 1'b0);
    finish_test();
  end
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end
endmodule
bind afp_top afp_checker chk (
  .mclk(mclk), .reset(reset), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
  .res_valid(res_valid), .scan_done(scan_done), .conv_wr(conv_wr), .conv_reg(conv_reg),
  .setup_reg(setup_reg), .avg_reg(avg_reg), .eoc_n(eoc_n), .conv_abort(conv_abort),
  .fifo_corrupt(fifo_corrupt), .fifo_ovf(fifo_ovf), .fifo_level(fifo_level)
);
`default_nettype wire
